// [rtl/host_cmd_int_regs.sv]
`timescale 1ns/100ps
`include "hc_regs_map.svh"

// Summary of operation
// - command register write of one sets bits
// - command register reads are side-effect free
// - overrun flagged when schedule misses frame end
// - overrun bumps counter and sets flag
// - counter bits 17:16, read-only, wraps
// - counter counts even while flag set
// - reset bit starts soft reset to suspend
// - device clears reset bit when done
// - soft reset finishes within 10 ms
// - soft reset leaves root hub alone
// - events set matching status flag
// - irq when flag, enable, master enable
// - writing one clears a status flag
// - device never clears flags itself
// - software writes cannot set flags
// - frame start flag set each frame
// - frame wrap flag on msb toggle
// - resume flag on resume signaling onset
// - root hub flag on port status change
module host_cmd_int_regs #(
  parameter int unsigned SOFT_RESET_LEN = `SOFT_RESET_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // frame timing and root hub events
  input wire host_regs_pkg::host_events_type events,
  // controller side
  output logic irq,
  output logic soft_reset_active,
  output logic enter_suspend
);

  localparam int unsigned RST_CNT_W = 24;
  // the real limit; a shortened simulation default must stay below it
  localparam int unsigned RST_LIMIT = `SOFT_RESET_CYCLES;

  // write and read channel holding registers
  logic aw_held_r;
  logic [`ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  host_regs_pkg::axi_rd_type rd_r;

  // register state
  logic soft_reset_r;
  logic [`CS_OVR_CNT_W-1:0] ovr_cnt_r;
  logic [`INT_FLAGS_W-1:0] flags_r;
  logic [`INT_FLAGS_W-1:0] flags_nxt;
  logic [`INT_FLAGS_W-1:0] enable_r;
  logic master_en_r;
  logic irq_r;
  logic suspend_r;
  logic fn_msb_r;
  logic resume_r;
  logic [RST_CNT_W-1:0] rst_cnt_r;
  host_regs_pkg::soft_reset_state_type rst_state_r;

  // address decode and write strobes
  wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
  wire [31:0] wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] wr_bits = w_data_r & wr_mask;
  wire wr_cmd = wr_fire && (aw_addr_r == `CMD_STATUS_ADDR);
  wire wr_flags = wr_fire && (aw_addr_r == `INT_FLAGS_ADDR);
  wire wr_enable = wr_fire && (aw_addr_r == `INT_ENABLE_ADDR);
  wire wr_hit = wr_cmd || wr_flags || wr_enable;
  wire rd_fire = s_axi_arvalid && arready_r;
  wire rd_cmd = s_axi_araddr == `CMD_STATUS_ADDR;
  wire rd_flags = s_axi_araddr == `INT_FLAGS_ADDR;
  wire rd_enable = s_axi_araddr == `INT_ENABLE_ADDR;
  wire rd_hit = rd_cmd || rd_flags || rd_enable;

  // command/status and flag views; reserved bits are zero
  wire [31:0] cmd_view = {14'h0000, ovr_cnt_r, 15'h0000, soft_reset_r};
  wire [31:0] flags_view = {25'h0000000, flags_r & `INT_FLAGS_MASK};
  wire [31:0] enable_view = {master_en_r, 24'h000000, enable_r & `INT_FLAGS_MASK};
  wire [31:0] rd_mux = rd_cmd ? cmd_view : rd_flags ? flags_view : rd_enable ? enable_view : 32'h0;

  // hardware events
  wire ev_overrun = events.sched_overrun;
  wire ev_frame_wrap = events.frame_num_msb != fn_msb_r;
  wire ev_resume = events.resume_seen && !resume_r;
  wire [`INT_FLAGS_W-1:0] ev_set = {
    events.root_hub_change,
    ev_frame_wrap,
    events.fatal_error,
    ev_resume,
    events.frame_start,
    1'b0,
    ev_overrun
  };
  wire [`INT_FLAGS_W-1:0] sw_clr = wr_flags ? wr_bits[`INT_FLAGS_W-1:0] : 7'h00;
  wire soft_reset_done = (rst_state_r == host_regs_pkg::RST_BUSY)
    && (rst_cnt_r == RST_CNT_W'(SOFT_RESET_LEN - 1));

  // set wins over clear; only software clears, only events set
  always_comb begin
    flags_nxt = ((flags_r & ~sw_clr) | ev_set) & `INT_FLAGS_MASK;
  end

  // axi write path; each ready is a flop of its own so the port is registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
      aw_addr_r <= `ADDR_W'h00;
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        awready_r <= 1'b1;
        w_held_r <= 1'b0;
        wready_r <= 1'b1;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // axi read path; reads change no state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rd_r <= '0;
    end else if (rd_fire) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rd_r.data <= rd_mux;
      rd_r.resp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // edge trackers follow their pins through reset, so no false edge follows it
  always_ff @(posedge clk) begin
    fn_msb_r <= events.frame_num_msb;
    resume_r <= events.resume_seen;
  end

  // soft reset sequencer; no root hub or port reset leaves this block
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_state_r <= host_regs_pkg::RST_IDLE;
      rst_cnt_r <= RST_CNT_W'(0);
      suspend_r <= 1'b0;
    end else begin
      case (rst_state_r)
        host_regs_pkg::RST_IDLE: begin
          rst_cnt_r <= RST_CNT_W'(0);
          if (soft_reset_r) begin
            rst_state_r <= host_regs_pkg::RST_BUSY;
            suspend_r <= 1'b1;
          end
        end
        host_regs_pkg::RST_BUSY: begin
          rst_cnt_r <= rst_cnt_r + RST_CNT_W'(1);
          if (soft_reset_done) begin
            rst_state_r <= host_regs_pkg::RST_IDLE;
          end
        end
        default: rst_state_r <= host_regs_pkg::RST_IDLE;
      endcase
    end
  end

  // command/status register: write-one-to-set, cleared by sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_reset_r <= 1'b0;
      ovr_cnt_r <= `CS_OVR_CNT_RESET;
    end else begin
      // a command landing on the finishing cycle wins and starts another reset
      if (wr_cmd && wr_bits[`CS_SOFT_RESET_BIT]) begin
        soft_reset_r <= 1'b1;
      end else if (soft_reset_done) begin
        soft_reset_r <= 1'b0;
      end
      if (ev_overrun) begin
        ovr_cnt_r <= ovr_cnt_r + `CS_OVR_CNT_W'(1);
      end
    end
  end

  // interrupt flags and enables; soft reset clears enables only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= 7'h00;
      enable_r <= 7'h00;
      master_en_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      if (soft_reset_done) begin
        enable_r <= 7'h00;
        master_en_r <= 1'b0;
      end else if (wr_enable) begin
        enable_r <= enable_r | wr_bits[`INT_FLAGS_W-1:0];
        master_en_r <= master_en_r | wr_bits[`INT_MASTER_BIT];
      end
      irq_r <= master_en_r && |(flags_r & enable_r);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rd_r.data;
  assign s_axi_rresp = rd_r.resp;
  assign irq = irq_r;
  assign soft_reset_active = soft_reset_r;
  assign enter_suspend = suspend_r;

  a_ovr_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    ev_overrun |=> ovr_cnt_r == $past(ovr_cnt_r) + 2'h1 && flags_r[`INT_SCHED_OVR_BIT])
    else $error("overrun count or flag did not update");
  a_ovr_count_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !ev_overrun |=> $stable(ovr_cnt_r))
    else $error("overrun count moved without an overrun");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    flags_r[`INT_FRAME_START_BIT] && !(wr_flags && wr_bits[`INT_FRAME_START_BIT])
    |=> flags_r[`INT_FRAME_START_BIT])
    else $error("status flag dropped without a clear");
  a_flag_no_sw_set: assert property (@(posedge clk) disable iff (!rst_n)
    !flags_r[`INT_ROOT_HUB_BIT] && !events.root_hub_change |=> !flags_r[`INT_ROOT_HUB_BIT])
    else $error("status flag set without an event");
  a_flag_w1c: assert property (@(posedge clk) disable iff (!rst_n)
    wr_flags && wr_bits[`INT_RESUME_BIT] && !ev_resume |=> !flags_r[`INT_RESUME_BIT])
    else $error("write one did not clear flag");
  a_frame_wrap_set: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(events.frame_num_msb) |-> ##1 flags_r[`INT_FRAME_WRAP_BIT])
    else $error("frame wrap flag missed msb toggle");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 irq == $past(master_en_r && |(flags_r & enable_r)))
    else $error("interrupt output disagrees with gating");
  a_soft_reset_bound: assert property (@(posedge clk) disable iff (!rst_n)
    rst_state_r == host_regs_pkg::RST_BUSY |-> rst_cnt_r < RST_CNT_W'(RST_LIMIT))
    else $error("soft reset ran past its limit");
  a_cmd_read_view: assert property (@(posedge clk) disable iff (!rst_n)
    rd_fire && rd_cmd |=> s_axi_rdata[31:18] == 14'h0 && s_axi_rdata[15:1] == 15'h0)
    else $error("reserved command bits read nonzero");

  sequence s_reset_request;
    wr_cmd && wr_bits[`CS_SOFT_RESET_BIT];
  endsequence
  sequence s_reset_finish;
    soft_reset_done && !(wr_cmd && wr_bits[`CS_SOFT_RESET_BIT]);
  endsequence
  a_soft_reset_start: assert property (@(posedge clk) disable iff (!rst_n)
    s_reset_request |=> soft_reset_r ##1 enter_suspend)
    else $error("reset command did not start a soft reset");
  a_soft_reset_end: assert property (@(posedge clk) disable iff (!rst_n)
    s_reset_finish |=> !soft_reset_r && rst_state_r == host_regs_pkg::RST_IDLE)
    else $error("soft reset bit not cleared at the end");
  a_event_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
    |ev_set |=> (flags_r & $past(ev_set)) == $past(ev_set))
    else $error("event did not set its status flag");

endmodule

// [rtl/hc_regs_map.svh]
`ifndef HOST_REGS_MAP_SVH
`define HOST_REGS_MAP_SVH

// register indices; byte address is four times the index
`define CMD_STATUS_IDX 4'h2
`define INT_FLAGS_IDX 4'h3
`define CMD_STATUS_ADDR 6'h08
`define INT_FLAGS_ADDR 6'h0C
`define INT_ENABLE_ADDR 6'h10
`define ADDR_W 6

// command/status fields
`define CS_SOFT_RESET_BIT 0
`define CS_OVR_CNT_LSB 16
`define CS_OVR_CNT_W 2
`define CS_OVR_CNT_RESET 2'h0

// interrupt flag positions
`define INT_SCHED_OVR_BIT 0
`define INT_FRAME_START_BIT 2
`define INT_RESUME_BIT 3
`define INT_FATAL_BIT 4
`define INT_FRAME_WRAP_BIT 5
`define INT_ROOT_HUB_BIT 6
`define INT_FLAGS_W 7
`define INT_FLAGS_MASK 7'h7D
`define INT_MASTER_BIT 31

// soft reset timing
`define SOFT_RESET_MAX_NS 10000000
`define CLK_PERIOD_NS 40
`define SOFT_RESET_CYCLES (`SOFT_RESET_MAX_NS / `CLK_PERIOD_NS)
`define SOFT_RESET_DEFAULT 32'h0000_03E8

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/hc_regs_pkg.sv]
package host_regs_pkg;

  typedef struct packed {
    logic sched_overrun;
    logic frame_start;
    logic resume_seen;
    logic fatal_error;
    logic frame_num_msb;
    logic root_hub_change;
  } host_events_type;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } axi_rd_type;

  typedef enum logic [1:0] {
    RST_IDLE,
    RST_BUSY
  } soft_reset_state_type;

endpackage

// [dv/host_drv.sv]
`timescale 1ns/100ps
// register-bus master standing in for the host driver
module host_drv (
  // clock
  input wire logic clk,
  // write channels
  output logic [5:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [5:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end

  // the leading edge keeps back-to-back calls from driving a signal twice at once
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
`include "hc_regs_map.svh"
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  host_regs_pkg::host_events_type events = '0;
  host_regs_pkg::host_events_type ev;
  logic irq, soft_reset_active, enter_suspend;
  logic [6:0] exp_f = '0;
  logic [1:0] exp_c = '0;
  int n_mismatch = 0, checked = 0, cycles = 0, seed = 91004, i, k;

  always #20 clk = ~clk;

  host_cmd_int_regs #(.SOFT_RESET_LEN(8)) i_host_cmd_int_regs (.clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events, .irq,
    .soft_reset_active, .enter_suspend);

  host_drv drv (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // flag image after one event cycle; pulses count per high cycle, frame msb on change, resume on its rise
  function automatic logic [6:0] nxt_flags(logic [6:0] f, host_regs_pkg::host_events_type p, n);
    return f | {n.root_hub_change, n.frame_num_msb ^ p.frame_num_msb, n.fatal_error,
      n.resume_seen & ~p.resume_seen, n.frame_start, 1'b0, n.sched_overrun};
  endfunction

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    drv.rd(`CMD_STATUS_ADDR, d, r);
    chk({r, d}, 34'h0);
    // reserved and read-only bits ignore ones, the reset command alone takes effect
    drv.wr(`CMD_STATUS_ADDR, 32'hFFFF_FFFF, r);
    // the suspend request is launched one edge after the command bit lands
    @(posedge clk);
    chk({soft_reset_active, enter_suspend}, 2'h3);
    drv.rd(`CMD_STATUS_ADDR, d, r);
    chk(d, 32'h1);
    for (k = 0; k < 40 && soft_reset_active !== 1'b0; k++) @(posedge clk);
    chk(k < 12, 1'b1);
    drv.rd(`CMD_STATUS_ADDR, d, r);
    chk(d, 32'h0);
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 14; i++) begin
        @(posedge clk);
        d = $random(seed);
        ev = events;
        {ev.sched_overrun, ev.frame_start, ev.resume_seen} = d[2:0];
        {ev.fatal_error, ev.frame_num_msb, ev.root_hub_change} = d[5:3];
        exp_f = nxt_flags(exp_f, events, ev);
        exp_c = exp_c + 2'(ev.sched_overrun);
        events <= ev;
      end
      // let the last random cycle reach the design before the pulses drop
      @(posedge clk);
      ev.sched_overrun = 1'b0;
      ev.frame_start = 1'b0;
      ev.fatal_error = 1'b0;
      ev.root_hub_change = 1'b0;
      events <= ev;
      drv.rd(`CMD_STATUS_ADDR, d, r);
      chk(d, {14'h0, exp_c, 16'h0});
      drv.rd(`INT_FLAGS_ADDR, d, r);
      chk(d, {25'h0, exp_f});
      d = $random(seed);
      drv.wr(`INT_FLAGS_ADDR, d, r);
      chk(r, `RESP_OKAY);
      exp_f = exp_f & ~d[6:0];
      drv.rd(`INT_FLAGS_ADDR, d, r);
      chk(d, {25'h0, exp_f});
    end
    drv.wr(`INT_FLAGS_ADDR, 32'hFFFF_FFFF, r);
    drv.wr(`INT_ENABLE_ADDR, 32'h0000_0004, r);
    @(posedge clk);
    events.frame_start <= 1'b1;
    @(posedge clk);
    events.frame_start <= 1'b0;
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    drv.wr(`INT_ENABLE_ADDR, 32'h8000_0000, r);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    drv.wr(`INT_FLAGS_ADDR, 32'h0000_0004, r);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    drv.wr(6'h20, 32'h1, r);
    chk(r, `RESP_SLVERR);
    drv.rd(6'h24, d, r);
    chk({r, d}, {`RESP_SLVERR, 32'h0});
    drv.rd(`INT_ENABLE_ADDR, d, r);
    chk(d, 32'h8000_0004);
    // a second soft reset clears the enables
    drv.wr(`CMD_STATUS_ADDR, 32'h0000_0001, r);
    for (k = 0; k < 40 && soft_reset_active !== 1'b0; k++) @(posedge clk);
    chk(k < 12, 1'b1);
    drv.rd(`INT_ENABLE_ADDR, d, r);
    chk(d, 32'h0);
    report_and_stop();
  end
endmodule
